/* frame_buffer_and_statistics_params.svh */
// Offsets, field positions, limits and reset values of the buffer block
`ifndef FRAME_BUFFER_AND_STATISTICS_PARAMS_SVH
`define FRAME_BUFFER_AND_STATISTICS_PARAMS_SVH
`define FBS_ADDR_W 8
`define FBS_OFS_CTRL 8'h00
`define FBS_OFS_SLOTS 8'h04
`define FBS_OFS_STATUS 8'h08
`define FBS_OFS_M2W 8'h0c
`define FBS_OFS_W2M 8'h10
`define FBS_OFS_CNT_BASE 8'h40
`define FBS_CNT_NUM 24
`define FBS_CTRL_FLOW_BIT 0
`define FBS_CTRL_COLDROP_BIT 1
`define FBS_CTRL_HALF_BIT 2
`define FBS_STATUS_BUFSEL_BIT 3
`define FBS_CTRL_RESET 3'h0
`define FBS_SLOTS_RESET 6'h01
`define FBS_SLOTS_MAX 6'h20
`define FBS_LEN_MAX 12'h7ef
`define FBS_LEN_MIN 12'h040
`define FBS_M2W_LARGE 10'h200
`define FBS_M2W_PER_SLOT 10'h020
`define FBS_M2W_SMALL_MAX 10'h100
`define FBS_W2M_FIXED 10'h100
`define FBS_CAP_SHIFT 16
`endif

/* fbs_pkg.sv */
// Types shared by the frame buffer and statistics block
package fbs_pkg;
   typedef logic [11:0] frame_len_t;
   typedef logic [9:0] frame_occ_t;
   typedef logic [31:0] stat_word_t;
   typedef enum logic [4:0] {
      CNT_WAN_RX_FRAME = 5'b00000,
      CNT_WAN_RX_BYTE = 5'b00001,
      CNT_WAN_RX_CHECK_ERR = 5'b00010,
      CNT_WAN_RX_LONG = 5'b00011,
      CNT_WAN_RX_SHORT = 5'b00100,
      CNT_WAN_RX_DROP = 5'b00101,
      CNT_LAN_TX_ERR = 5'b00110,
      CNT_LAN_TX_GOOD_BYTE = 5'b00111,
      CNT_LAN_TX_GOOD_FRAME = 5'b01000,
      CNT_LAN_TX_PAUSE = 5'b01001,
      CNT_LAN_COLLISION = 5'b01010,
      CNT_LAN_EXCESS_COL = 5'b01011,
      CNT_LAN_RX_TOTAL_BYTE = 5'b01100,
      CNT_LAN_RX_SHORT = 5'b01101,
      CNT_LAN_RX_LONG = 5'b01110,
      CNT_LAN_RX_CHECK_ERR = 5'b01111,
      CNT_LAN_RX_BCAST = 5'b10000,
      CNT_LAN_RX_GROUP = 5'b10001,
      CNT_LAN_RX_GOOD_FRAME = 5'b10010,
      CNT_LAN_RX_GOOD_BYTE = 5'b10011,
      CNT_LAN_RX_DROP = 5'b10100,
      CNT_WAN_TX_LEN_ERR = 5'b10101,
      CNT_WAN_TX_BYTE = 5'b10110,
      CNT_WAN_TX_FRAME = 5'b10111
   } cnt_idx_t;
endpackage

/* frame_buffer_and_statistics.sv */
// Frame buffer occupancy, statistics counters and APB register file
`timescale 1ns/1ps
`include "frame_buffer_and_statistics_params.svh"

// Functional notes
// - Memory clock runs at half core clock
// - Memory split into two directional frame buffers
// - WAN-to-MII buffer has fixed capacity
// - Select pin high: MII-to-WAN holds 512 frames
// - Select pin low: capacity scales with timeslots
// - Select pin level readable as status bit
// - Count all WAN received frames and bytes
// - Count WAN check errors, long, short frames
// - Store only good frames; count full drops
// - Count long or short frames fetched by MAC
// - Count good bytes and frames sent to PHY
// - Count sent pause frames when flow control on
// - Half duplex: count collisions and excess drops
// - Count every byte received from the PHY
// - Count short, long, check errors exclusive
// - Count broadcast and multicast without errors; long or short frames still counted
// - Count good frames and bytes only
// - Half duplex collision fragments not counted short
// - Flow control off: count full buffer drops
// - Count WAN send length errors, frames, bytes
// - Over 2031 long, under 64 short
module frame_buffer_and_statistics import fbs_pkg::*; (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`FBS_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic buffer_size_select_pin_i,
   output logic memory_clock_output_o,
   output logic flow_control_enable_o,
   output logic excess_collision_drop_enable_o,
   output logic half_duplex_o,
   input wire logic wan_rx_end_i,
   input wire logic [11:0] wan_rx_len_i,
   input wire logic wan_rx_check_ok_i,
   output logic w2m_store_o,
   input wire logic lan_tx_fetch_i,
   input wire logic [11:0] lan_tx_fetch_len_i,
   input wire logic lan_tx_done_i,
   input wire logic [11:0] lan_tx_len_i,
   input wire logic lan_tx_pause_i,
   input wire logic lan_collision_i,
   input wire logic lan_excess_col_i,
   input wire logic lan_rx_byte_i,
   input wire logic lan_rx_end_i,
   input wire logic [11:0] lan_rx_len_i,
   input wire logic lan_rx_check_ok_i,
   input wire logic lan_rx_broadcast_i,
   input wire logic lan_rx_group_i,
   input wire logic lan_rx_collided_i,
   output logic m2w_store_o,
   input wire logic wan_tx_fetch_i,
   input wire logic [11:0] wan_tx_fetch_len_i,
   input wire logic wan_tx_done_i,
   input wire logic [11:0] wan_tx_bytes_i
);

   function automatic logic is_long(input frame_len_t len);
      is_long = (len > `FBS_LEN_MAX);
   endfunction

   function automatic logic is_short(input frame_len_t len);
      is_short = (len < `FBS_LEN_MIN);
   endfunction

   function automatic stat_word_t widen(input frame_len_t len);
      widen = {20'h00000, len};
   endfunction

   function automatic frame_occ_t next_occ(input frame_occ_t occ,
                                           input logic put,
                                           input logic take);
      logic do_take;
      do_take = take && (occ != 10'h000);
      next_occ = occ + {9'h000, put} - {9'h000, do_take};
   endfunction

   // Register state
   logic [2:0] ctrl;
   logic [5:0] slots;
   logic bufsel_meta;
   logic bufsel;
   logic mclk;
   frame_occ_t w2m_occ;
   frame_occ_t m2w_occ;
   stat_word_t cnt [0:`FBS_CNT_NUM-1];

   wire flow_en = ctrl[`FBS_CTRL_FLOW_BIT];
   wire coldrop_en = ctrl[`FBS_CTRL_COLDROP_BIT];
   wire half_en = ctrl[`FBS_CTRL_HALF_BIT];

   // MII-to-WAN capacity from the pin mode and the slot count
   wire [5:0] slots_used = (slots == 6'h00) ? 6'h01 : slots;
   // One bit wider than the capacity: 32 slots times 32 frames is 1024
   wire [10:0] small_raw = {5'h00, slots_used} * 11'(`FBS_M2W_PER_SLOT);
   wire [9:0] small_cap = (small_raw > 11'(`FBS_M2W_SMALL_MAX)) ?
                          `FBS_M2W_SMALL_MAX : small_raw[9:0];
   wire [9:0] m2w_cap = bufsel ? `FBS_M2W_LARGE : small_cap;
   wire [9:0] w2m_cap = `FBS_W2M_FIXED;

   // WAN receive path
   wire wan_rx_long = is_long(wan_rx_len_i);
   wire wan_rx_short = is_short(wan_rx_len_i);
   wire w2m_offer = wan_rx_end_i && wan_rx_check_ok_i;
   wire w2m_room = (w2m_occ < w2m_cap);
   wire w2m_put = w2m_offer && w2m_room;
   wire w2m_drop = w2m_offer && !w2m_room;

   // MAC transmit path
   wire lan_tx_bad = lan_tx_fetch_i &&
        (is_long(lan_tx_fetch_len_i) || is_short(lan_tx_fetch_len_i));

   // MAC receive path; collision fragments in half duplex are dropped
   wire rx_fragment = half_en && lan_rx_collided_i;
   wire rx_frame = lan_rx_end_i && !rx_fragment;
   wire rx_long = is_long(lan_rx_len_i);
   wire rx_short = is_short(lan_rx_len_i);
   wire rx_len_bad = rx_long || rx_short;
   wire rx_good = rx_frame && lan_rx_check_ok_i && !rx_len_bad;
   wire m2w_room = (m2w_occ < m2w_cap);
   wire m2w_put = rx_good && m2w_room;
   wire m2w_drop = rx_good && !m2w_room && !flow_en;

   // WAN transmit path
   wire wan_tx_bad = wan_tx_fetch_i &&
        (is_long(wan_tx_fetch_len_i) || is_short(wan_tx_fetch_len_i));

   // Increment per counter, zero when nothing qualifies
   stat_word_t amt [0:`FBS_CNT_NUM-1];
   assign amt[CNT_WAN_RX_FRAME] = {31'h0, wan_rx_end_i};
   assign amt[CNT_WAN_RX_BYTE] =
          wan_rx_end_i ? widen(wan_rx_len_i) : 32'h0;
   assign amt[CNT_WAN_RX_CHECK_ERR] =
          {31'h0, wan_rx_end_i && !wan_rx_check_ok_i};
   assign amt[CNT_WAN_RX_LONG] =
          {31'h0, wan_rx_end_i && wan_rx_long};
   assign amt[CNT_WAN_RX_SHORT] =
          {31'h0, wan_rx_end_i && wan_rx_short};
   assign amt[CNT_WAN_RX_DROP] = {31'h0, w2m_drop};
   assign amt[CNT_LAN_TX_ERR] = {31'h0, lan_tx_bad};
   assign amt[CNT_LAN_TX_GOOD_BYTE] =
          lan_tx_done_i ? widen(lan_tx_len_i) : 32'h0;
   assign amt[CNT_LAN_TX_GOOD_FRAME] = {31'h0, lan_tx_done_i};
   assign amt[CNT_LAN_TX_PAUSE] =
          {31'h0, lan_tx_pause_i && flow_en};
   assign amt[CNT_LAN_COLLISION] =
          {31'h0, lan_collision_i && half_en};
   assign amt[CNT_LAN_EXCESS_COL] =
          {31'h0, lan_excess_col_i && half_en && coldrop_en};
   assign amt[CNT_LAN_RX_TOTAL_BYTE] = {31'h0, lan_rx_byte_i};
   assign amt[CNT_LAN_RX_SHORT] = {31'h0, rx_frame && rx_short};
   assign amt[CNT_LAN_RX_LONG] = {31'h0, rx_frame && rx_long};
   assign amt[CNT_LAN_RX_CHECK_ERR] =
          {31'h0, rx_frame && !lan_rx_check_ok_i && !rx_len_bad};
   assign amt[CNT_LAN_RX_BCAST] =
          {31'h0, rx_frame && lan_rx_check_ok_i &&
           lan_rx_broadcast_i};
   assign amt[CNT_LAN_RX_GROUP] =
          {31'h0, rx_frame && lan_rx_check_ok_i && lan_rx_group_i &&
           !lan_rx_broadcast_i};
   assign amt[CNT_LAN_RX_GOOD_FRAME] = {31'h0, rx_good};
   assign amt[CNT_LAN_RX_GOOD_BYTE] =
          rx_good ? widen(lan_rx_len_i) : 32'h0;
   assign amt[CNT_LAN_RX_DROP] = {31'h0, m2w_drop};
   assign amt[CNT_WAN_TX_LEN_ERR] = {31'h0, wan_tx_bad};
   assign amt[CNT_WAN_TX_BYTE] =
          wan_tx_done_i ? widen(wan_tx_bytes_i) : 32'h0;
   assign amt[CNT_WAN_TX_FRAME] = {31'h0, wan_tx_done_i};

   // APB decode; registers answer in the access cycle after setup
   wire setup = psel_i && !penable_i;
   wire access = psel_i && penable_i && pready_o;
   wire wr_access = access && pwrite_i;
   wire in_cnt = (paddr_i >= `FBS_OFS_CNT_BASE) &&
        (paddr_i < `FBS_OFS_CNT_BASE + 8'(4 * `FBS_CNT_NUM)) &&
        (paddr_i[1:0] == 2'b00);
   wire [7:0] cnt_ofs = paddr_i - `FBS_OFS_CNT_BASE;
   wire [4:0] cnt_sel = cnt_ofs[6:2];
   wire hit_ctrl = (paddr_i == `FBS_OFS_CTRL);
   wire hit_slots = (paddr_i == `FBS_OFS_SLOTS);
   wire hit_status = (paddr_i == `FBS_OFS_STATUS);
   wire hit_m2w = (paddr_i == `FBS_OFS_M2W);
   wire hit_w2m = (paddr_i == `FBS_OFS_W2M);
   wire hit_rw = hit_ctrl || hit_slots;
   wire hit_ro = hit_status || hit_m2w || hit_w2m || in_cnt;
   // Writes to read-only or unmapped words are refused with an error
   wire bad = pwrite_i ? !hit_rw : !(hit_rw || hit_ro);
   wire [5:0] wr_slots = (pwdata_i[5:0] > `FBS_SLOTS_MAX) ?
        `FBS_SLOTS_MAX : pwdata_i[5:0];

   stat_word_t status_word;
   stat_word_t m2w_word;
   stat_word_t w2m_word;
   stat_word_t rd_word;
   assign status_word =
          32'(bufsel) << `FBS_STATUS_BUFSEL_BIT;
   assign m2w_word = (32'(m2w_cap) << `FBS_CAP_SHIFT) | 32'(m2w_occ);
   assign w2m_word = (32'(w2m_cap) << `FBS_CAP_SHIFT) | 32'(w2m_occ);
   assign rd_word = hit_ctrl ? {29'h0, ctrl} :
                    hit_slots ? {26'h0, slots} :
                    hit_status ? status_word :
                    hit_m2w ? m2w_word :
                    hit_w2m ? w2m_word :
                    in_cnt ? cnt[cnt_sel] : 32'h0;

   // Bus response: pready, read data and error all from flops
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= setup;
         prdata_o <= (setup && !pwrite_i) ? rd_word : 32'h0;
         pslverr_o <= setup && bad;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ctrl <= `FBS_CTRL_RESET;
         slots <= `FBS_SLOTS_RESET;
      end else if (wr_access && hit_ctrl) begin
         ctrl <= pwdata_i[2:0];
      end else if (wr_access && hit_slots) begin
         slots <= wr_slots;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         flow_control_enable_o <= 1'b0;
         excess_collision_drop_enable_o <= 1'b0;
         half_duplex_o <= 1'b0;
      end else begin
         flow_control_enable_o <= flow_en;
         excess_collision_drop_enable_o <= coldrop_en;
         half_duplex_o <= half_en;
      end
   end

   // The pin is asynchronous to the core clock
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         bufsel_meta <= 1'b0;
         bufsel <= 1'b0;
      end else begin
         bufsel_meta <= buffer_size_select_pin_i;
         bufsel <= bufsel_meta;
      end
   end

   // Memory clock: toggled every rising core edge gives exactly half rate
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         mclk <= 1'b0;
      end else begin
         mclk <= !mclk;
      end
   end
   assign memory_clock_output_o = mclk;

   // Frame occupancy of both buffers; a fetch from empty is ignored
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         w2m_occ <= 10'h000;
         m2w_occ <= 10'h000;
         w2m_store_o <= 1'b0;
         m2w_store_o <= 1'b0;
      end else begin
         w2m_occ <= next_occ(w2m_occ, w2m_put, lan_tx_fetch_i);
         m2w_occ <= next_occ(m2w_occ, m2w_put, wan_tx_fetch_i);
         w2m_store_o <= w2m_put;
         m2w_store_o <= m2w_put;
      end
   end

   // Counters wrap at 32 bits; they are never cleared except by reset
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < `FBS_CNT_NUM; i++) begin
            cnt[i] <= 32'h0;
         end
      end else begin
         for (int i = 0; i < `FBS_CNT_NUM; i++) begin
            cnt[i] <= cnt[i] + amt[i];
         end
      end
   end

endmodule

/* frame_buffer_and_statistics_assertions.sv */
// Port-level checks for the frame buffer and statistics block
`timescale 1ns/1ps
module fbs_checker (
   input wire logic clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic pready_o, pslverr_o, memory_clock_output_o,
   input wire logic flow_control_enable_o, wan_rx_end_i, wan_rx_check_ok_i,
   input wire logic w2m_store_o, lan_rx_end_i, lan_rx_check_ok_i,
   input wire logic [11:0] lan_rx_len_i,
   input wire logic m2w_store_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   chk_mclk_half: assert property ($past(resetn_i) |->
      memory_clock_output_o != $past(memory_clock_output_o))
      else $error("memory clock did not toggle");
   chk_w2m_good: assert property (w2m_store_o |->
      $past(wan_rx_end_i && wan_rx_check_ok_i))
      else $error("bad frame stored toward lan");
   chk_m2w_good: assert property (m2w_store_o |->
      $past(lan_rx_end_i && lan_rx_check_ok_i && lan_rx_len_i >= 12'h040
      && lan_rx_len_i <= 12'h7ef)) else $error("bad frame stored toward wan");
   chk_ready_next: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready in access cycle");
   chk_ready_one: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   chk_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   chk_rdata_idle: assert property (!pready_o |-> prdata_o == '0)
      else $error("read data outside access");
   chk_unmapped_err: assert property (psel_i && !penable_i &&
      paddr_i == 8'h20 |=> pslverr_o) else $error("unmapped not refused");
   chk_flow_copy: assert property (psel_i && penable_i && pready_o &&
      pwrite_i && paddr_i == 8'h00 |=> ##1
      flow_control_enable_o == $past(pwdata_i[0], 2))
      else $error("flow enable copy wrong");
   cov_w2m: cover property (w2m_store_o);
   cov_m2w: cover property (m2w_store_o);
   cov_err: cover property (pslverr_o);
endmodule

bind frame_buffer_and_statistics fbs_checker u_chk (.clk_sys_i, .resetn_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
   .pslverr_o, .memory_clock_output_o, .flow_control_enable_o, .wan_rx_end_i,
   .wan_rx_check_ok_i, .w2m_store_o, .lan_rx_end_i, .lan_rx_check_ok_i,
   .lan_rx_len_i, .m2w_store_o);

/* sdram_stub.sv */
// Behavioural stand-in for the external buffer memory
`timescale 1ns/1ps
module sdram_stub #(
   parameter int BANKS = 4,
   parameter int CAS_LATENCY = 2,
   parameter int BURST_LEN = 8
) (
   input wire logic memory_clock_i,
   output int rise_count
);
   // Only the clock pin reaches the memory here, so edges are all we see
   initial rise_count = 0;
   always @(posedge memory_clock_i) rise_count <= rise_count + 1;
endmodule

/* frame_buffer_and_statistics_tb.sv */
// Self-checking bench for the frame buffer and statistics block
`timescale 1ns/1ps
module frame_buffer_and_statistics_tb import fbs_pkg::*;;
   logic clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, rd;
   logic pready_o, pslverr_o, buffer_size_select_pin_i = 0, er;
   logic memory_clock_output_o, flow_control_enable_o, half_duplex_o;
   logic excess_collision_drop_enable_o, w2m_store_o, m2w_store_o;
   logic wan_rx_end_i = 0, wan_rx_check_ok_i = 0, lan_tx_fetch_i = 0;
   logic lan_tx_done_i = 0, lan_tx_pause_i = 0, lan_collision_i = 0;
   logic lan_excess_col_i = 0, lan_rx_byte_i = 0, lan_rx_end_i = 0;
   logic lan_rx_check_ok_i = 0, lan_rx_broadcast_i = 0, lan_rx_group_i = 0;
   logic lan_rx_collided_i = 0, wan_tx_fetch_i = 0, wan_tx_done_i = 0;
   logic [11:0] wan_rx_len_i = '0, lan_tx_fetch_len_i = '0, lan_tx_len_i = '0;
   logic [11:0] lan_rx_len_i = '0, wan_tx_fetch_len_i = '0, wan_tx_bytes_i = '0;
   int mismatches = 0, samples_checked = 0, cycles = 0, rises, r0;
   frame_buffer_and_statistics DUT (.clk_sys_i, .resetn_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
      .pslverr_o, .buffer_size_select_pin_i, .memory_clock_output_o,
      .flow_control_enable_o, .excess_collision_drop_enable_o, .half_duplex_o,
      .wan_rx_end_i, .wan_rx_len_i, .wan_rx_check_ok_i, .w2m_store_o,
      .lan_tx_fetch_i, .lan_tx_fetch_len_i, .lan_tx_done_i, .lan_tx_len_i,
      .lan_tx_pause_i, .lan_collision_i, .lan_excess_col_i, .lan_rx_byte_i,
      .lan_rx_end_i, .lan_rx_len_i, .lan_rx_check_ok_i, .lan_rx_broadcast_i,
      .lan_rx_group_i, .lan_rx_collided_i, .m2w_store_o, .wan_tx_fetch_i,
      .wan_tx_fetch_len_i, .wan_tx_done_i, .wan_tx_bytes_i);
   sdram_stub u_mem (.memory_clock_i(memory_clock_output_o), .rise_count(rises));
   always #4 clk_sys_i = ~clk_sys_i;
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out;
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (n >= 16) mismatches++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, logic [31:0] x);
      apb(1'b0, a, '0);
      check(nm, rd, x);
   endtask
   task automatic cnt(input cnt_idx_t i, input logic [31:0] x);
      rchk(i.name(), 8'h40 + {1'b0, i, 2'b00}, x);
   endtask
   // Qualifier bits: [3] check good, [2] broadcast, [1] group, [0] collided
   task automatic drive(input int k, input logic [11:0] n, logic [3:0] q);
      wan_rx_end_i <= k == 0;
      lan_rx_end_i <= k == 1;
      lan_tx_fetch_i <= k == 2;
      lan_tx_done_i <= k == 3;
      wan_tx_fetch_i <= k == 4;
      wan_tx_done_i <= k == 5;
      lan_tx_pause_i <= k == 6;
      lan_collision_i <= k == 7;
      lan_excess_col_i <= k == 8;
      lan_rx_byte_i <= k == 9;
      {wan_rx_len_i, lan_tx_fetch_len_i, lan_tx_len_i} <= {3{n}};
      {lan_rx_len_i, wan_tx_fetch_len_i, wan_tx_bytes_i} <= {3{n}};
      {wan_rx_check_ok_i, lan_rx_check_ok_i} <= {2{q[3]}};
      {lan_rx_broadcast_i, lan_rx_group_i, lan_rx_collided_i} <= q[2:0];
   endtask
   task automatic ev(input int k, input logic [11:0] n, logic [3:0] q);
      @(posedge clk_sys_i);
      drive(k, n, q);
      @(posedge clk_sys_i);
      drive(15, '0, '0);
   endtask
   task automatic pin(input logic v);
      @(posedge clk_sys_i);
      buffer_size_select_pin_i <= v;
      repeat (4) @(posedge clk_sys_i);
   endtask
   task automatic t_reset;
      rchk("slots", 8'h04, 32'h1);
      rchk("m2w", 8'h0c, 32'h0020_0000);
      rchk("w2m", 8'h10, 32'h0100_0000);
      r0 = rises;
      repeat (20) @(posedge clk_sys_i);
      check("mclk", rises - r0, 32'ha);
      $display("reset done");
   endtask
   task automatic t_mode;
      pin(1'b1);
      rchk("status", 8'h08, 32'h8);
      rchk("m2w", 8'h0c, 32'h0200_0000);
      apb(1'b1, 8'h04, 32'h2);
      rchk("w2m", 8'h10, 32'h0100_0000);
      pin(1'b0);
      rchk("status", 8'h08, 32'h0);
      rchk("m2w", 8'h0c, 32'h0040_0000);
      apb(1'b1, 8'h04, 32'h3f);
      rchk("m2w", 8'h0c, 32'h0100_0000);
      apb(1'b1, 8'h04, 32'h1);
      $display("mode done");
   endtask
   task automatic t_wan_rx;
      ev(0, 12'h064, 4'h8);
      @(posedge clk_sys_i);
      check("w2m store", w2m_store_o, 1'b1);
      ev(0, 12'h064, 4'h0);
      ev(0, 12'h7f0, 4'h8);
      ev(0, 12'h03f, 4'h8);
      ev(0, 12'h040, 4'h8);
      ev(0, 12'h7ef, 4'h8);
      cnt(CNT_WAN_RX_FRAME, 32'h6);
      cnt(CNT_WAN_RX_BYTE, 32'h1126);
      cnt(CNT_WAN_RX_CHECK_ERR, 32'h1);
      cnt(CNT_WAN_RX_LONG, 32'h1);
      cnt(CNT_WAN_RX_SHORT, 32'h1);
      $display("wan rx done");
   endtask
   task automatic t_refused;
      apb(1'b1, 8'h40, 32'h5);
      check("cnt err", er, 1'b1);
      cnt(CNT_WAN_RX_FRAME, 32'h6);
      apb(1'b1, 8'h08, '1);
      check("status err", er, 1'b1);
      rchk("unmapped", 8'h20, 32'h0);
      check("unmapped err", er, 1'b1);
      $display("refused done");
   endtask
   task automatic t_lan_rx;
      ev(1, 12'h064, 4'he);
      @(posedge clk_sys_i);
      check("m2w store", m2w_store_o, 1'b1);
      ev(1, 12'h050, 4'ha);
      ev(1, 12'h064, 4'h4);
      ev(1, 12'h7f0, 4'h8);
      ev(1, 12'h03f, 4'h0);
      repeat (3) ev(9, '0, '0);
      apb(1'b1, 8'h00, 32'h4);
      ev(1, 12'h01e, 4'h1);
      cnt(CNT_LAN_RX_BCAST, 32'h1);
      cnt(CNT_LAN_RX_GROUP, 32'h1);
      cnt(CNT_LAN_RX_CHECK_ERR, 32'h1);
      cnt(CNT_LAN_RX_LONG, 32'h1);
      cnt(CNT_LAN_RX_SHORT, 32'h1);
      cnt(CNT_LAN_RX_GOOD_FRAME, 32'h2);
      cnt(CNT_LAN_RX_GOOD_BYTE, 32'hb4);
      cnt(CNT_LAN_RX_TOTAL_BYTE, 32'h3);
      $display("lan rx done");
   endtask
   task automatic t_drops;
      apb(1'b1, 8'h00, 32'h0);
      repeat (4) ev(4, 12'h064, '0);
      repeat (33) ev(1, 12'h064, 4'h8);
      cnt(CNT_LAN_RX_DROP, 32'h1);
      apb(1'b1, 8'h00, 32'h1);
      ev(1, 12'h064, 4'h8);
      cnt(CNT_LAN_RX_DROP, 32'h1);
      rchk("m2w", 8'h0c, 32'h0020_0020);
      repeat (6) ev(2, 12'h064, '0);
      repeat (257) ev(0, 12'h064, 4'h8);
      cnt(CNT_WAN_RX_DROP, 32'h1);
      rchk("w2m", 8'h10, 32'h0100_0100);
      $display("drops done");
   endtask
   task automatic t_tx;
      apb(1'b1, 8'h00, 32'h7);
      repeat (2) @(posedge clk_sys_i);
      check("ctrl outs", {excess_collision_drop_enable_o, half_duplex_o,
         flow_control_enable_o}, 32'h7);
      ev(2, 12'h7f0, '0);
      ev(2, 12'h03f, '0);
      ev(2, 12'h040, '0);
      ev(3, 12'h064, '0);
      ev(6, '0, '0);
      ev(7, '0, '0);
      ev(8, '0, '0);
      apb(1'b1, 8'h00, 32'h1);
      ev(7, '0, '0);
      ev(4, 12'h7f0, '0);
      ev(4, 12'h03f, '0);
      repeat (2) ev(5, 12'h06a, '0);
      cnt(CNT_LAN_TX_ERR, 32'h2);
      cnt(CNT_LAN_TX_GOOD_BYTE, 32'h64);
      cnt(CNT_LAN_TX_GOOD_FRAME, 32'h1);
      cnt(CNT_LAN_TX_PAUSE, 32'h1);
      cnt(CNT_LAN_COLLISION, 32'h1);
      cnt(CNT_LAN_EXCESS_COL, 32'h1);
      cnt(CNT_WAN_TX_LEN_ERR, 32'h2);
      cnt(CNT_WAN_TX_BYTE, 32'hd4);
      cnt(CNT_WAN_TX_FRAME, 32'h2);
      $display("tx done");
   endtask
   initial begin
      repeat (10) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      t_reset;
      t_mode;
      t_wan_rx;
      t_refused;
      t_lan_rx;
      t_drops;
      t_tx;
      close_out;
   end
endmodule
